/* moag_pkg.sv */
// Purpose: shared constants for the memory operand address generator
// Assumes: aclk at 200 MHz, synchronous active-low reset
// Notes:   register map is the generator's own control/status window
package moag_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_PAIR_TWO  = 8'h04;
    localparam logic [7:0] OFF_PAIR_THR  = 8'h08;
    localparam logic [7:0] OFF_BYTE_A    = 8'h0c;
    localparam logic [7:0] OFF_BANK      = 8'h10;
    localparam logic [7:0] OFF_STATUS    = 8'h14;

    // ctrl fields
    localparam int CTRL_BANK_LO = 0;
    localparam int CTRL_BANK_HI = 1;
    localparam int CTRL_REDUCED = 2;
    // bank register fields
    localparam int BANK_PLAIN_LSB = 0;
    localparam int BANK_SUB_LSB   = 4;

    // reset values
    localparam logic [3:0]  BANK_RST = 4'h0;
    localparam logic [15:0] PAIR_RST = 16'h0000;

    // short direct limits
    localparam logic [15:0] SADDR_LO   = 16'hfe20;
    localparam logic [15:0] SADDR_HI   = 16'hff1f;
    localparam logic [15:0] SADDRP_HI  = 16'hff1e;

    // operand mode codes
    typedef enum logic [3:0] {
        MOAG_M_IND      = 4'h0,
        MOAG_M_IND_INC  = 4'h1,
        MOAG_M_IND_DEC  = 4'h3,
        MOAG_M_BASED    = 4'h2,
        MOAG_M_IDX      = 4'h6,
        MOAG_M_RESTRICT = 4'h7,
        MOAG_M_SADDR    = 4'h5,
        MOAG_M_SADDRP   = 4'h4
    } moag_mode_e;

    // register selector codes
    localparam logic [1:0] SEL_PAIR_TWO = 2'h0;
    localparam logic [1:0] SEL_PAIR_THR = 2'h1;
    localparam logic [1:0] SEL_SP       = 2'h2;
    localparam logic [1:0] SEL_BYTE_B   = 2'h3;
    localparam logic [1:0] SEL_ACC      = 2'h2;

    typedef enum logic [1:0] {
        MOAG_ST_IDLE   = 2'b00,
        MOAG_ST_ACCESS = 2'b01,
        MOAG_ST_UPDATE = 2'b11
    } moag_state_e;

endpackage : moag_pkg

/* moag_regbank.sv */
// Purpose: four banks of pointer pairs and byte registers
// Assumes: one writer at a time, software write wins over auto-update
// Notes:   bank chosen by the two bank-select flags
module moag_regbank #(
    parameter int BANKS = 4
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [1:0]  bank_sel,
    input  wire logic        sw_we,
    input  wire logic [1:0]  sw_sel,
    input  wire logic [15:0] sw_data,
    input  wire logic        upd_we,
    input  wire logic        upd_thr,
    input  wire logic [15:0] upd_data,
    output logic      [15:0] pair_two,
    output logic      [15:0] pair_thr,
    output logic      [7:0]  acc,
    output logic      [7:0]  byte_b
);
    logic [15:0] two_q [BANKS];
    logic [15:0] thr_q [BANKS];
    logic [15:0] ab_q  [BANKS];

    for (genvar g = 0; g < BANKS; g++) begin : g_bank
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                two_q[g] <= moag_pkg::PAIR_RST;
                thr_q[g] <= moag_pkg::PAIR_RST;
                ab_q[g]  <= moag_pkg::PAIR_RST;
            end else if (sw_we && bank_sel == 2'(g)) begin
                case (sw_sel)
                    moag_pkg::SEL_PAIR_TWO: two_q[g] <= sw_data;
                    moag_pkg::SEL_PAIR_THR: thr_q[g] <= sw_data;
                    default:                ab_q[g]  <= sw_data;
                endcase
            end else if (upd_we && bank_sel == 2'(g)) begin
                if (upd_thr) begin
                    thr_q[g] <= upd_data;
                end else begin
                    two_q[g] <= upd_data;
                end
            end
        end
    end

    // selected bank only
    assign pair_two = two_q[bank_sel];
    assign pair_thr = thr_q[bank_sel];
    assign acc      = ab_q[bank_sel][7:0];
    assign byte_b   = ab_q[bank_sel][15:8];
endmodule : moag_regbank

/* moag_top.sv */
// Purpose: effective address generation for indirect memory operands
// Assumes: AXI4-Lite register access, one access request at a time
// Notes:   address and bank lines are registered, valid one access cycle
//
// Overview of operation
// - Plain register indirect uses the chosen pointer pair as the address.
// - Auto-increment or auto-decrement updates the pair only after the access.
// - Six indirect forms are decoded: plain, increment, decrement on either pair.
// - The restricted group accepts only plain indirect through either pair.
// - Based mode adds a zero-extended byte offset to pair two, pair three or the stack pointer.
// - Based mode drops the carry out of bit 15.
// - Indexed mode adds a 16-bit table address to acc, byte register or a pair, bytes zero-extended.
// - Indexed mode keeps only the low 16 bits of the sum.
// - Registers are read from the bank chosen by the two bank-select flags.
// - Every mode except short direct reaches the whole space via four extension bits; in the reduced variant only prefixed accesses do.
// - In the reduced variant the plain bank register reads as zero.
// - Short direct byte covers FE20H-FF1FH and pair covers FE20H-FF1EH only.
// - Without the prefix the plain bank value drives the extension lines during the access.
// - With the prefix the sub-bank value drives the extension lines during the access.
// - Bank registers hold their value until software rewrites them.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module moag_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // access request
    input  wire logic        req_valid,
    input  wire logic [3:0]  req_mode,
    input  wire logic [1:0]  req_sel,
    input  wire logic        req_sub_bank,
    input  wire logic [7:0]  req_offset,
    input  wire logic [15:0] req_word,
    input  wire logic [15:0] sp_value,
    output logic             req_ready,
    output logic             mem_valid,
    output logic [15:0]      mem_addr,
    output logic [3:0]       ext_addr,
    output logic             mem_error,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    moag_pkg::moag_state_e state_q;
    logic [2:0]  ctrl_q;
    logic [3:0]  plain_bank_register_q;
    logic [3:0]  sub_bank_register_q;
    logic [15:0] pair_two;
    logic [15:0] pair_thr;
    logic [7:0]  acc;
    logic [7:0]  byte_b;
    logic [15:0] base_d;
    logic [15:0] addr_d;
    logic        ok_d;
    logic        upd_thr_q;
    logic        upd_dec_q;
    logic        upd_pend_q;
    logic [15:0] upd_val;
    logic        sw_we;
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic [31:0] rd_d;
    logic        rd_ok;
    logic [3:0]  plain_eff;
    logic [7:0]  addr_hi_cnt_q;

    // reduced variant forces plain bank to zero
    assign plain_eff = ctrl_q[moag_pkg::CTRL_REDUCED] ? 4'h0 : plain_bank_register_q;

    // ---------------- register bank ----------------
    assign sw_we = aw_hold_q && w_hold_q && !s_axi_bvalid && (aw_addr_q == moag_pkg::OFF_PAIR_TWO
                   || aw_addr_q == moag_pkg::OFF_PAIR_THR || aw_addr_q == moag_pkg::OFF_BYTE_A);

    // post update wraps in 16 bits, bank bits untouched
    assign upd_val = upd_dec_q ? 16'((upd_thr_q ? pair_thr : pair_two) - 16'h0001)
                               : 16'((upd_thr_q ? pair_thr : pair_two) + 16'h0001);

    moag_regbank #(.BANKS(4)) u_bank (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .bank_sel ({ctrl_q[moag_pkg::CTRL_BANK_HI], ctrl_q[moag_pkg::CTRL_BANK_LO]}),
        .sw_we    (sw_we),
        .sw_sel   (aw_addr_q == moag_pkg::OFF_PAIR_TWO ? moag_pkg::SEL_PAIR_TWO :
                   aw_addr_q == moag_pkg::OFF_PAIR_THR ? moag_pkg::SEL_PAIR_THR : moag_pkg::SEL_BYTE_B),
        .sw_data  (w_data_q[15:0]),
        .upd_we   (upd_pend_q),
        .upd_thr  (upd_thr_q),
        .upd_data (upd_val),
        .pair_two (pair_two),
        .pair_thr (pair_thr),
        .acc      (acc),
        .byte_b   (byte_b)
    );

    // ---------------- address decode ----------------
    always_comb begin
        base_d = 16'h0000;
        addr_d = 16'h0000;
        ok_d   = 1'b1;
        case (req_sel)
            moag_pkg::SEL_PAIR_TWO: base_d = pair_two;
            moag_pkg::SEL_PAIR_THR: base_d = pair_thr;
            default:                base_d = pair_two;
        endcase
        case (moag_pkg::moag_mode_e'(req_mode))
            moag_pkg::MOAG_M_IND, moag_pkg::MOAG_M_IND_INC, moag_pkg::MOAG_M_IND_DEC: begin
                // six forms: three updates by two pairs
                addr_d = base_d;
                ok_d   = req_sel[1] == 1'b0;
            end
            moag_pkg::MOAG_M_RESTRICT: begin
                addr_d = base_d;
                ok_d   = req_sel[1] == 1'b0;
            end
            moag_pkg::MOAG_M_BASED: begin
                case (req_sel)
                    moag_pkg::SEL_SP: addr_d = 16'(sp_value + {8'h00, req_offset});
                    moag_pkg::SEL_BYTE_B: ok_d = 1'b0;
                    default: addr_d = 16'(base_d + {8'h00, req_offset});
                endcase
            end
            moag_pkg::MOAG_M_IDX: begin
                // carry past bit 15 is simply dropped
                case (req_sel)
                    moag_pkg::SEL_ACC:    addr_d = 16'(req_word + {8'h00, acc});
                    moag_pkg::SEL_BYTE_B: addr_d = 16'(req_word + {8'h00, byte_b});
                    default:              addr_d = 16'(req_word + base_d);
                endcase
            end
            moag_pkg::MOAG_M_SADDR: begin
                addr_d = req_word;
                ok_d   = req_word >= moag_pkg::SADDR_LO && req_word <= moag_pkg::SADDR_HI;
            end
            moag_pkg::MOAG_M_SADDRP: begin
                addr_d = req_word;
                ok_d   = req_word >= moag_pkg::SADDR_LO && req_word <= moag_pkg::SADDRP_HI;
            end
            default: ok_d = 1'b0;
        endcase
    end

    // ---------------- access sequencer ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= moag_pkg::MOAG_ST_IDLE;
            req_ready  <= 1'b0;
            mem_valid  <= 1'b0;
            mem_addr   <= 16'h0000;
            ext_addr   <= 4'h0;
            mem_error  <= 1'b0;
            upd_pend_q <= 1'b0;
            upd_thr_q  <= 1'b0;
            upd_dec_q  <= 1'b0;
        end else begin
            mem_valid  <= 1'b0;
            mem_error  <= 1'b0;
            upd_pend_q <= 1'b0;
            ext_addr   <= 4'h0;
            req_ready  <= 1'b0;
            case (state_q)
                moag_pkg::MOAG_ST_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        if (ok_d) begin
                            mem_valid <= 1'b1;
                            mem_addr  <= addr_d;
                            // bank lines only during the access
                            // short direct stays in the base 64k, no bank bits
                            ext_addr  <= (req_mode[3:1] == 3'b010) ? 4'h0
                                         : req_sub_bank ? sub_bank_register_q : plain_eff;
                            state_q   <= moag_pkg::MOAG_ST_ACCESS;
                            upd_thr_q <= req_sel[0];
                            upd_dec_q <= req_mode == moag_pkg::MOAG_M_IND_DEC;
                        end else begin
                            mem_error <= 1'b1;
                        end
                    end
                end
                moag_pkg::MOAG_ST_ACCESS: begin
                    // pointer changes after the access cycle
                    upd_pend_q <= req_mode == moag_pkg::MOAG_M_IND_INC
                                  || req_mode == moag_pkg::MOAG_M_IND_DEC;
                    state_q    <= moag_pkg::MOAG_ST_UPDATE;
                end
                moag_pkg::MOAG_ST_UPDATE: state_q <= moag_pkg::MOAG_ST_IDLE;
                default: state_q <= moag_pkg::MOAG_ST_IDLE;
            endcase
        end
    end

    // ---------------- axi4-lite slave ----------------
    assign rd_ok = s_axi_araddr inside {moag_pkg::OFF_CTRL, moag_pkg::OFF_PAIR_TWO, moag_pkg::OFF_PAIR_THR,
                                        moag_pkg::OFF_BYTE_A, moag_pkg::OFF_BANK, moag_pkg::OFF_STATUS};
    always_comb begin
        rd_d = 32'h0000_0000;
        case (s_axi_araddr)
            moag_pkg::OFF_CTRL:     rd_d = {29'h0, ctrl_q};
            moag_pkg::OFF_PAIR_TWO: rd_d = {16'h0, pair_two};
            moag_pkg::OFF_PAIR_THR: rd_d = {16'h0, pair_thr};
            moag_pkg::OFF_BYTE_A:   rd_d = {16'h0, byte_b, acc};
            moag_pkg::OFF_BANK:     rd_d = {24'h0, sub_bank_register_q, plain_eff};
            moag_pkg::OFF_STATUS:   rd_d = {addr_hi_cnt_q, 4'h0, ext_addr, mem_addr};
            default:                rd_d = 32'h0000_0000;
        endcase
    end

    // count of rejected operands, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_hi_cnt_q <= 8'h00;
        end else if (mem_error && addr_hi_cnt_q != 8'hff) begin
            addr_hi_cnt_q <= 8'(addr_hi_cnt_q + 8'h01);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q     <= 1'b1;
                aw_addr_q     <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q inside {moag_pkg::OFF_CTRL, moag_pkg::OFF_PAIR_TWO,
                                 moag_pkg::OFF_PAIR_THR, moag_pkg::OFF_BYTE_A, moag_pkg::OFF_BANK,
                                 moag_pkg::OFF_STATUS}) ? 2'b00 : 2'b10;
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ctrl and bank registers hold until rewritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q                <= 3'h0;
            plain_bank_register_q <= moag_pkg::BANK_RST;
            sub_bank_register_q   <= moag_pkg::BANK_RST;
        end else if (aw_hold_q && w_hold_q && !s_axi_bvalid && w_strb_q[0]) begin
            if (aw_addr_q == moag_pkg::OFF_CTRL) begin
                ctrl_q <= w_data_q[2:0];
            end
            if (aw_addr_q == moag_pkg::OFF_BANK) begin
                plain_bank_register_q <= w_data_q[moag_pkg::BANK_PLAIN_LSB +: 4];
                sub_bank_register_q   <= w_data_q[moag_pkg::BANK_SUB_LSB +: 4];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_d;
                s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : moag_top

/* moag_mem_model.sv */
// Purpose: memory side of the address generator, records each access
// Assumes: one access per mem_valid pulse
// Notes:   keeps the full 20-bit address seen on the bus
module moag_mem_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        mem_valid,
    input  wire logic [15:0] mem_addr,
    input  wire logic [3:0]  ext_addr,
    output logic      [19:0] last_q,
    output int               count_q
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_q  <= 20'h00000;
            count_q <= 0;
        end else if (mem_valid) begin
            // bank bits on top reach the whole 1m space
            last_q  <= {ext_addr, mem_addr};
            count_q <= count_q + 1;
        end
    end
endmodule : moag_mem_model

/* moag_top_checker.sv */
// Purpose: port-level assertions for the address generator
// Assumes: bound to moag_top, one clock domain
// Notes:   register-dependent sums are checked by the bench
module moag_top_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        req_valid,
    input wire logic [3:0]  req_mode,
    input wire logic [1:0]  req_sel,
    input wire logic [7:0]  req_offset,
    input wire logic [15:0] req_word,
    input wire logic [15:0] sp_value,
    input wire logic        req_ready,
    input wire logic        mem_valid,
    input wire logic [15:0] mem_addr,
    input wire logic [3:0]  ext_addr,
    input wire logic        mem_error
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire take = req_valid && req_ready;

    ready_gap_a: assert property (mem_valid |-> !req_ready [*3] ##1 req_ready)
        else $error("request ready gap wrong");
    one_answer_a: assert property (take |=> mem_valid != mem_error)
        else $error("no single answer after request");
    no_spurious_a: assert property (mem_valid || mem_error |-> $past(take))
        else $error("answer without request");
    ext_idle_a: assert property (!mem_valid |-> ext_addr == 4'h0)
        else $error("extension bits outside access");
    addr_hold_a: assert property (mem_valid |=> !mem_valid && $stable(mem_addr))
        else $error("address pulse or hold wrong");
    saddr_ok_a: assert property (take && req_mode == moag_pkg::MOAG_M_SADDR && req_word >= moag_pkg::SADDR_LO
        && req_word <= moag_pkg::SADDR_HI |=> mem_valid && mem_addr == $past(req_word))
        else $error("short direct address wrong");
    saddr_range_a: assert property (take && req_mode[3:1] == 3'b010 && (req_word < moag_pkg::SADDR_LO
        || req_word > (req_mode[0] ? moag_pkg::SADDR_HI : moag_pkg::SADDRP_HI)) |=> mem_error)
        else $error("short direct range not refused");
    based_sp_a: assert property (take && req_mode == moag_pkg::MOAG_M_BASED && req_sel == moag_pkg::SEL_SP
        |=> mem_valid && mem_addr == $past(sp_value) + {8'h00, $past(req_offset)})
        else $error("based stack address wrong");
    restrict_a: assert property (take && req_mode == moag_pkg::MOAG_M_RESTRICT && req_sel[1] |=> mem_error)
        else $error("restricted group accepted bad register");
endmodule : moag_top_checker

bind moag_top moag_top_checker u_moag_top_checker (.aclk, .aresetn, .req_valid, .req_mode, .req_sel, .req_offset,
    .req_word, .sp_value, .req_ready, .mem_valid, .mem_addr, .ext_addr, .mem_error);

/* memory_operand_address_gen_tb.sv */
// Purpose: self-checking bench for the address generator
// Assumes: bank 0 pairs set over axi before the table runs
// Notes:   access outputs sampled at the falling edge to stay race free, axi outputs right after the rising edge
module memory_operand_address_gen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0]  mode;
        logic [1:0]  sel;
        logic        sub;
        logic [7:0]  off;
        logic [15:0] word;
        logic        err;
        logic [15:0] addr;
        logic [3:0]  ext;
    } moag_row_s;
    logic        aclk = 1'b0, aresetn = 1'b0, req_valid = 1'b0, req_sub_bank = 1'b0;
    logic [3:0]  req_mode = 4'h0, s_axi_wstrb = 4'hf, ext_addr;
    logic [1:0]  req_sel = 2'h0, s_axi_bresp, s_axi_rresp;
    logic [7:0]  req_offset = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [15:0] req_word = 16'h0000, sp_value = 16'h8000, mem_addr;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        req_ready, mem_valid, mem_error;
    logic [19:0] last_q;
    int          count_q, miscompares = 0, comparisons = 0;
    // modes: 0 plain, 1 inc, 3 dec, 2 based, 6 indexed, 7 restricted, 5 saddr, 4 saddr pair
    moag_row_s   rows [15] = '{
        '{4'h0, 2'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 16'h1234, 4'h5},
        '{4'h0, 2'h1, 1'b1, 8'h00, 16'h0000, 1'b0, 16'hfff0, 4'h9},
        '{4'h2, 2'h1, 1'b0, 8'h20, 16'h0000, 1'b0, 16'h0010, 4'h5},
        '{4'h2, 2'h2, 1'b1, 8'hff, 16'h0000, 1'b0, 16'h80ff, 4'h9},
        '{4'h2, 2'h0, 1'b0, 8'h80, 16'h0000, 1'b0, 16'h12b4, 4'h5},
        '{4'h6, 2'h0, 1'b0, 8'h00, 16'hf000, 1'b0, 16'h0234, 4'h5},
        '{4'h6, 2'h2, 1'b1, 8'h00, 16'h0100, 1'b0, 16'h01f7, 4'h9},
        '{4'h6, 2'h3, 1'b0, 8'h00, 16'hffff, 1'b0, 16'h0080, 4'h5},
        '{4'h6, 2'h1, 1'b0, 8'h00, 16'h0010, 1'b0, 16'h0000, 4'h5},
        '{4'h7, 2'h1, 1'b1, 8'h00, 16'h0000, 1'b0, 16'hfff0, 4'h9},
        '{4'h7, 2'h2, 1'b0, 8'h00, 16'h0000, 1'b1, 16'h0000, 4'h0},
        '{4'h5, 2'h0, 1'b0, 8'h00, 16'hff1f, 1'b0, 16'hff1f, 4'h0},
        '{4'h5, 2'h0, 1'b0, 8'h00, 16'hfe1f, 1'b1, 16'h0000, 4'h0},
        '{4'h4, 2'h0, 1'b0, 8'h00, 16'hfe20, 1'b0, 16'hfe20, 4'h0},
        '{4'h4, 2'h0, 1'b0, 8'h00, 16'hff1f, 1'b1, 16'h0000, 4'h0}
    };

    moag_top u_moag_top (.aclk, .aresetn, .req_valid, .req_mode, .req_sel, .req_sub_bank, .req_offset, .req_word,
        .sp_value, .req_ready, .mem_valid, .mem_addr, .ext_addr, .mem_error, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    moag_mem_model u_moag_mem_model (.aclk, .aresetn, .mem_valid, .mem_addr, .ext_addr, .last_q, .count_q);

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // one write or one read; each channel released on its own handshake
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid  <= wr;
        s_axi_bready  <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready  <= !wr;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        check("axi_resp", wr ? s_axi_bresp : s_axi_rresp, er);
        if (!wr)
            check("axi_rdata", s_axi_rdata, d);
    endtask : axi

    task automatic access(input moag_row_s r);
        bit seen;
        seen = 1'b0;
        @(posedge aclk);
        req_mode     <= r.mode;
        req_sel      <= r.sel;
        req_sub_bank <= r.sub;
        req_offset   <= r.off;
        req_word     <= r.word;
        req_valid    <= 1'b1;
        repeat (40) if (!seen) begin
            @(negedge aclk);
            seen = (req_ready === 1'b1);
            @(posedge aclk);
        end
        req_valid <= 1'b0;
        @(negedge aclk);
        check("mem_error", mem_error, r.err);
        check("mem_valid", mem_valid, !r.err);
        if (!r.err)
            check("mem_addr", mem_addr, r.addr);
        if (!r.err)
            check("ext_addr", ext_addr, r.ext);
        @(negedge aclk);
        if (!r.err)
            check("model_addr", last_q, {r.ext, r.addr});
        check("ready_low", req_ready, r.err);
    endtask : access

    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        check("rst_ready", req_ready, 1'b0);
        check("rst_valid", mem_valid, 1'b0);
        @(posedge aclk);
        aresetn <= 1'b1;
        axi(0, moag_pkg::OFF_BANK, 32'h00000000, 2'h0);
        axi(1, moag_pkg::OFF_PAIR_TWO, 32'h00001234, 2'h0);
        axi(1, moag_pkg::OFF_PAIR_THR, 32'h0000fff0, 2'h0);
        axi(1, moag_pkg::OFF_BYTE_A, 32'h000081f7, 2'h0);
        axi(1, moag_pkg::OFF_BANK, 32'h00000095, 2'h0);
        foreach (rows[i])
            access(rows[i]);
        access(moag_row_s'{4'h2, 2'h3, 1'b0, 8'h00, 16'h0, 1'b1, 16'h0000, 4'h0});
        // post update lands after the access, wraps within 16 bits
        access(moag_row_s'{4'h1, 2'h0, 1'b0, 8'h00, 16'h0, 1'b0, 16'h1234, 4'h5});
        access(moag_row_s'{4'h0, 2'h0, 1'b0, 8'h00, 16'h0, 1'b0, 16'h1235, 4'h5});
        axi(1, moag_pkg::OFF_PAIR_THR, 32'h00000000, 2'h0);
        access(moag_row_s'{4'h3, 2'h1, 1'b1, 8'h00, 16'h0, 1'b0, 16'h0000, 4'h9});
        access(moag_row_s'{4'h1, 2'h1, 1'b0, 8'h00, 16'h0, 1'b0, 16'hffff, 4'h5});
        access(moag_row_s'{4'h0, 2'h1, 1'b0, 8'h00, 16'h0, 1'b0, 16'h0000, 4'h5});
        axi(0, moag_pkg::OFF_PAIR_TWO, 32'h00001235, 2'h0);
        // other banks hold their own pairs
        axi(1, moag_pkg::OFF_CTRL, 32'h00000001, 2'h0);
        axi(1, moag_pkg::OFF_PAIR_TWO, 32'h0000abcd, 2'h0);
        access(moag_row_s'{4'h0, 2'h0, 1'b0, 8'h00, 16'h0, 1'b0, 16'habcd, 4'h5});
        axi(1, moag_pkg::OFF_CTRL, 32'h00000002, 2'h0);
        access(moag_row_s'{4'h0, 2'h0, 1'b0, 8'h00, 16'h0, 1'b0, 16'h0000, 4'h5});
        axi(1, moag_pkg::OFF_CTRL, 32'h00000000, 2'h0);
        access(moag_row_s'{4'h0, 2'h0, 1'b0, 8'h00, 16'h0, 1'b0, 16'h1235, 4'h5});
        axi(0, moag_pkg::OFF_BANK, 32'h00000095, 2'h0);
        axi(1, moag_pkg::OFF_CTRL, 32'h00000004, 2'h0);
        access(moag_row_s'{4'h0, 2'h0, 1'b0, 8'h00, 16'h0, 1'b0, 16'h1235, 4'h0});
        access(moag_row_s'{4'h0, 2'h0, 1'b1, 8'h00, 16'h0, 1'b0, 16'h1235, 4'h9});
        axi(0, moag_pkg::OFF_BANK, 32'h00000090, 2'h0);
        // unmapped place refused without effect
        axi(1, 8'h20, 32'h0000ffff, 2'h2);
        axi(0, 8'h20, 32'h00000000, 2'h2);
        axi(0, moag_pkg::OFF_PAIR_TWO, 32'h00001235, 2'h0);
        axi(0, moag_pkg::OFF_STATUS, 32'h04001235, 2'h0);
        print_verdict();
    end
endmodule : memory_operand_address_gen_tb
